// File: rtl/swc_pkg.sv
// Purpose: constants and carrier types for the synth2 calibration wait / program count bank
// Assumes: 200 MHz core clock, 8-bit host register port
// Notes: wait periods are timed on the always-on clock, sampled as an enable tick
package swc_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam logic [7:0] ADDR_CAL_WAIT = 8'h85;
  localparam logic [7:0] ADDR_LOOP_BW = 8'h86;
  localparam logic [7:0] ADDR_PROG_CNT = 8'h88;
  localparam logic [1:0] CLSD_RESET = 2'h0;
  localparam logic [1:0] VCO_RESET = 2'h1;
  localparam logic LOOP_BW_RESET = 1'b0;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam int CLSD_LSB = 2;
  localparam int VCO_LSB = 0;
  // wait periods in microseconds, as counted in always-on clock ticks of 1 us
  localparam int unsigned CLSD_US0 = 30;
  localparam int unsigned CLSD_US1 = 300;
  localparam int unsigned CLSD_US2 = 30000;
  localparam int unsigned CLSD_US3 = 300000;
  localparam int unsigned VCO_US0 = 20;
  localparam int unsigned VCO_US1 = 400;
  localparam int unsigned VCO_US2 = 8000;
  localparam int unsigned VCO_US3 = 200000;
  localparam int WAIT_W = 19;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } swc_req_t;

  typedef enum logic [1:0] {
    SWC_IDLE = 2'b00,
    SWC_VCO = 2'b01,
    SWC_CLSD = 2'b11
  } swc_state_t;
endpackage

// File: rtl/swc_bank.sv
// Purpose: synth2 calibration wait control, loop bandwidth select, nv program cycle counter
// Assumes: aon_tick is a 1 us always-on clock pulse from outside, synchronised here
// Notes: nv memory engine is outside; it reports commit/program completion and data
// Operation
// - the closed loop wait code picks 30 us, 300 us, 30 ms or 300 ms and resets to 0.
// - the vco wait code picks 20 us, 400 us, 8 ms or 200 ms and resets to 1.
// - loop bandwidth select 1 drives the synthesizer to its 200 Hz jitter cleaner bandwidth.
// - loop bandwidth select 0, the reset value, keeps the normal clock generator bandwidth.
// - the counter adds one after every completed erase/program cycle on its own.
// - hardware writes the counter back to nv memory so it survives power cycles.
// - the counter reloads from nv memory after reset, after a commit and after each program.
// - the counter saturates at 255.
// - wait periods are timed by counting always-on clock cycles.
// - a commit from nv memory happens after reset and when software sets the commit bit.
`timescale 1ns/1ps
`default_nettype none
module swc_bank
  import swc_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // host register port
  input wire swc_req_t host_req,
  output logic [7:0] host_rdata,
  // nv memory engine
  input wire logic commit_sw,
  input wire logic commit_done,
  input wire logic prog_done,
  input wire logic [7:0] nv_cnt_value,
  output logic commit_start,
  output logic nv_cnt_wr,
  output logic [7:0] nv_cnt_wdata,
  // synthesizer calibration
  input wire logic aon_tick,
  input wire logic cal_start,
  output logic cal_busy,
  output logic jitter_clean_bw
);

  ////////////////////////////////////////////////////////////////////
  // pin synchroniser for the always-on tick
  logic aon_s1_q, aon_s2_q, aon_s3_q;
  logic aon_s1_d, aon_s2_d, aon_s3_d;
  logic tick;
  always_comb
  begin
    aon_s1_d = aon_tick;
    aon_s2_d = aon_s1_q;
    aon_s3_d = aon_s2_q;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      aon_s1_q <= 1'b0;
      aon_s2_q <= 1'b0;
      aon_s3_q <= 1'b0;
    end
    else if (clk_en)
    begin
      aon_s1_q <= aon_s1_d;
      aon_s2_q <= aon_s2_d;
      aon_s3_q <= aon_s3_d;
    end
  end
  assign tick = aon_s2_q & ~aon_s3_q; // rising edge, read from second and third stages

  ////////////////////////////////////////////////////////////////////
  // control registers and read mux
  logic [1:0] clsd_q, clsd_d, vco_q, vco_d;
  logic bw_q, bw_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] cnt_q;
  always_comb
  begin
    clsd_d = clsd_q;
    vco_d = vco_q;
    bw_d = bw_q;
    rdata_d = rdata_q;
    if (host_req.wr)
    begin
      // upper bits dropped, counter address ignored for writes
      if (host_req.addr == ADDR_CAL_WAIT)
      begin
        clsd_d = host_req.wdata[CLSD_LSB +: 2];
        vco_d = host_req.wdata[VCO_LSB +: 2];
      end
      else if (host_req.addr == ADDR_LOOP_BW)
        bw_d = host_req.wdata[0];
    end
    if (host_req.rd)
    begin
      if (host_req.addr == ADDR_CAL_WAIT)
        rdata_d = {4'h0, clsd_q, vco_q};
      else if (host_req.addr == ADDR_LOOP_BW)
        rdata_d = {7'h00, bw_q};
      else if (host_req.addr == ADDR_PROG_CNT)
        rdata_d = cnt_q;
      else
        rdata_d = 8'h00;
    end
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      clsd_q <= CLSD_RESET;
      vco_q <= VCO_RESET;
      bw_q <= LOOP_BW_RESET;
      rdata_q <= 8'h00;
    end
    else if (clk_en)
    begin
      clsd_q <= clsd_d;
      vco_q <= vco_d;
      bw_q <= bw_d;
      rdata_q <= rdata_d;
    end
  end
  assign host_rdata = rdata_q;
  assign jitter_clean_bw = bw_q;

  ////////////////////////////////////////////////////////////////////
  // program cycle counter with commit sequencing
  logic boot_q, boot_d, cstart_q, cstart_d;
  logic reload_q, reload_d, nvwr_q, nvwr_d;
  logic [7:0] cnt_d, nvw_q, nvw_d;
  always_comb
  begin
    boot_d = 1'b0;
    cstart_d = boot_q | commit_sw;
    cnt_d = cnt_q;
    reload_d = 1'b0;
    nvwr_d = 1'b0;
    nvw_d = nvw_q;
    if (reload_q)
      cnt_d = nv_cnt_value;
    if (commit_done)
      reload_d = 1'b1;
    if (prog_done)
    begin
      // the stored count is bumped first, then read back from memory
      nvwr_d = 1'b1;
      nvw_d = (cnt_q == CNT_MAX) ? CNT_MAX : cnt_q + CNT_ONE;
      cnt_d = nvw_d;
      reload_d = 1'b1;
    end
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      boot_q <= 1'b1;
      cstart_q <= 1'b0;
      cnt_q <= CNT_RESET;
      reload_q <= 1'b0;
      nvwr_q <= 1'b0;
      nvw_q <= CNT_RESET;
    end
    else if (clk_en)
    begin
      boot_q <= boot_d;
      cstart_q <= cstart_d;
      cnt_q <= cnt_d;
      reload_q <= reload_d;
      nvwr_q <= nvwr_d;
      nvw_q <= nvw_d;
    end
  end
  assign commit_start = cstart_q;
  assign nv_cnt_wr = nvwr_q;
  assign nv_cnt_wdata = nvw_q;

  ////////////////////////////////////////////////////////////////////
  // calibration wait sequencer, vco settle then closed loop settle
  swc_state_t st_q, st_d;
  logic [WAIT_W-1:0] wcnt_q, wcnt_d;
  logic busy_q, busy_d;
  function automatic logic [WAIT_W-1:0] clsd_len(input logic [1:0] c);
    case (c)
      2'h0: clsd_len = WAIT_W'(CLSD_US0);
      2'h1: clsd_len = WAIT_W'(CLSD_US1);
      2'h2: clsd_len = WAIT_W'(CLSD_US2);
      default: clsd_len = WAIT_W'(CLSD_US3);
    endcase
  endfunction
  function automatic logic [WAIT_W-1:0] vco_len(input logic [1:0] c);
    case (c)
      2'h0: vco_len = WAIT_W'(VCO_US0);
      2'h1: vco_len = WAIT_W'(VCO_US1);
      2'h2: vco_len = WAIT_W'(VCO_US2);
      default: vco_len = WAIT_W'(VCO_US3);
    endcase
  endfunction
  always_comb
  begin
    st_d = st_q;
    wcnt_d = wcnt_q;
    case (st_q)
      SWC_IDLE:
        if (cal_start)
        begin
          st_d = SWC_VCO;
          wcnt_d = vco_len(vco_q);
        end
      SWC_VCO:
        if (tick)
        begin
          if (wcnt_q <= WAIT_W'(1))
          begin
            st_d = SWC_CLSD;
            wcnt_d = clsd_len(clsd_q);
          end
          else
            wcnt_d = wcnt_q - WAIT_W'(1);
        end
      SWC_CLSD:
        if (tick)
        begin
          if (wcnt_q <= WAIT_W'(1))
            st_d = SWC_IDLE;
          else
            wcnt_d = wcnt_q - WAIT_W'(1);
        end
      default:
        st_d = SWC_IDLE;
    endcase
    busy_d = (st_d != SWC_IDLE);
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_q <= SWC_IDLE;
      wcnt_q <= '0;
      busy_q <= 1'b0;
    end
    else if (clk_en)
    begin
      st_q <= st_d;
      wcnt_q <= wcnt_d;
      busy_q <= busy_d;
    end
  end
  assign cal_busy = busy_q;
endmodule
`default_nettype wire

// File: sim/swc_bank_monitor.sv
// Purpose: port checker for swc_bank
// Assumes: one clock, sync active low reset
// Notes: bound to every swc_bank instance
`timescale 1ns/1ps
`default_nettype none
module swc_bank_monitor
  import swc_pkg::*;
(
  // clock
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // host
  input wire swc_req_t host_req,
  input wire logic [7:0] host_rdata,
  // nv engine
  input wire logic commit_sw,
  input wire logic commit_done,
  input wire logic prog_done,
  input wire logic [7:0] nv_cnt_value,
  input wire logic commit_start,
  input wire logic nv_cnt_wr,
  input wire logic [7:0] nv_cnt_wdata,
  // calibration
  input wire logic aon_tick,
  input wire logic cal_start,
  input wire logic cal_busy,
  input wire logic jitter_clean_bw
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a read of the unmapped hole at 0x87 must give zero
  property p_unmap; host_req.rd && clk_en && host_req.addr == 8'h87 |=> host_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("hole read");
  property p_bw_rd; host_req.rd && clk_en && host_req.addr == ADDR_LOOP_BW
    |=> host_rdata == {7'h00, jitter_clean_bw}; endproperty
  a_bw_rd: assert property (p_bw_rd) else $error("bw read");
  property p_bw_wr; host_req.wr && clk_en && host_req.addr == ADDR_LOOP_BW
    |=> jitter_clean_bw == $past(host_req.wdata[0]); endproperty
  a_bw_wr: assert property (p_bw_wr) else $error("bw write");
  property p_prog; prog_done && clk_en |=> nv_cnt_wr; endproperty
  a_prog: assert property (p_prog) else $error("no nv write");
  // a wrap to zero would show as a zero write-back
  property p_sat; nv_cnt_wr |-> nv_cnt_wdata != 8'h00; endproperty
  a_sat: assert property (p_sat) else $error("count wrapped");
  property p_commit; commit_sw && clk_en |=> commit_start ##1 !commit_start; endproperty
  a_commit: assert property (p_commit) else $error("no commit");
  property p_boot; $rose(rst_n) |=> commit_start; endproperty
  a_boot: assert property (p_boot) else $error("no boot commit");
  property p_cal; cal_start && clk_en && !cal_busy |=> cal_busy; endproperty
  a_cal: assert property (p_cal) else $error("no wait");
  c_prog: cover property (prog_done);
  c_commit: cover property (commit_done);
  c_cal: cover property ($fell(cal_busy));
endmodule
bind swc_bank swc_bank_monitor u_mon (
  .clk(clk),
  .rst_n(rst_n),
  .clk_en(clk_en),
  .host_req(host_req),
  .host_rdata(host_rdata),
  .commit_sw(commit_sw),
  .commit_done(commit_done),
  .prog_done(prog_done),
  .nv_cnt_value(nv_cnt_value),
  .commit_start(commit_start),
  .nv_cnt_wr(nv_cnt_wr),
  .nv_cnt_wdata(nv_cnt_wdata),
  .aon_tick(aon_tick),
  .cal_start(cal_start),
  .cal_busy(cal_busy),
  .jitter_clean_bw(jitter_clean_bw)
);
`default_nettype wire

// File: sim/swc_bank_test.sv
// Purpose: directed test of swc_bank
// Assumes: 1 us always-on tick made here
// Notes: wait codes 0 and 0 span 50 ticks
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module swc_bank_test
  import swc_pkg::*;
;
  logic clk = 0, rst_n = 0, clk_en = 1, commit_sw = 0, commit_done = 0;
  logic prog_done = 0, aon_tick = 0, cal_start = 0;
  logic commit_start, nv_cnt_wr, cal_busy, jitter_clean_bw;
  logic [7:0] nv_cnt_value = 8'h00, host_rdata, nv_cnt_wdata;
  swc_req_t host_req = '0;
  int n_mismatch = 0, checks_done = 0;
  always #2.5 clk = ~clk;
  // tick toggles on a clk falling edge, half a cycle from the sampling edge, and goes through the sync path
  always #500 aon_tick = ~aon_tick;
  swc_bank dut (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .host_req(host_req),
    .host_rdata(host_rdata),
    .commit_sw(commit_sw),
    .commit_done(commit_done),
    .prog_done(prog_done),
    .nv_cnt_value(nv_cnt_value),
    .commit_start(commit_start),
    .nv_cnt_wr(nv_cnt_wr),
    .nv_cnt_wdata(nv_cnt_wdata),
    .aon_tick(aon_tick),
    .cal_start(cal_start),
    .cal_busy(cal_busy),
    .jitter_clean_bw(jitter_clean_bw)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 host_req = '{w, !w, a, d};
    @(posedge clk);
    #1 host_req = '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    `CHK("host_rdata", e, host_rdata)
  endtask
  // one-cycle strobe; mask bits are commit_sw, commit_done, prog_done, cal_start
  task automatic pls(input logic [3:0] m);
    @(posedge clk);
    #1 {commit_sw, commit_done, prog_done, cal_start} = m;
    @(posedge clk);
    #1 {commit_sw, commit_done, prog_done, cal_start} = 4'h0;
  endtask
  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    // boot commit request stands for the cycle after the first edge out of reset
    @(posedge clk);
    #1 `CHK("commit_start", 1'b1, commit_start)
    rd(ADDR_CAL_WAIT, 8'h01);
    rd(ADDR_LOOP_BW, 8'h00);
    rd(ADDR_PROG_CNT, 8'h00);
    acc(1'b1, ADDR_CAL_WAIT, 8'hFF);
    rd(ADDR_CAL_WAIT, 8'h0F);
    acc(1'b1, ADDR_CAL_WAIT, 8'h05);
    rd(ADDR_CAL_WAIT, 8'h05);
    acc(1'b1, ADDR_LOOP_BW, 8'hFF);
    `CHK("jitter_clean_bw", 1'b1, jitter_clean_bw)
    rd(ADDR_LOOP_BW, 8'h01);
    acc(1'b1, ADDR_LOOP_BW, 8'h00);
    `CHK("jitter_clean_bw", 1'b0, jitter_clean_bw)
    // with the enable low a write must not land
    clk_en = 1'b0;
    acc(1'b1, ADDR_LOOP_BW, 8'h01);
    `CHK("jitter_clean_bw", 1'b0, jitter_clean_bw)
    clk_en = 1'b1;
    acc(1'b1, ADDR_PROG_CNT, 8'h5A);
    rd(ADDR_PROG_CNT, 8'h00);
    rd(8'h87, 8'h00);
    // reload on commit, then program twice, the second at the ceiling
    nv_cnt_value = 8'hFE;
    pls(4'h8);
    `CHK("commit_start", 1'b1, commit_start)
    pls(4'h4);
    repeat (2) @(posedge clk);
    rd(ADDR_PROG_CNT, 8'hFE);
    pls(4'h2);
    `CHK("nv_cnt_wr", 1'b1, nv_cnt_wr)
    `CHK("nv_cnt_wdata", 8'hFF, nv_cnt_wdata)
    nv_cnt_value = 8'hFF;
    rd(ADDR_PROG_CNT, 8'hFF);
    pls(4'h2);
    `CHK("nv_cnt_wdata", 8'hFF, nv_cnt_wdata)
    rd(ADDR_PROG_CNT, 8'hFF);
    // shortest wait: 20 us vco then 30 us closed loop
    acc(1'b1, ADDR_CAL_WAIT, 8'h00);
    pls(4'h1);
    #45000;
    `CHK("cal_busy", 1'b1, cal_busy)
    #7000;
    `CHK("cal_busy", 1'b0, cal_busy)
    complete_run();
  end
  // watchdog: the tests need about 53 us
  initial
  begin
    #200000;
    n_mismatch++;
    complete_run();
  end
endmodule
`default_nettype wire
